// ### pced_pkg.sv
// Package: constants and types of the port change edge detector
package pced_pkg;
    localparam int unsigned NUM_PINS     = 6;
    localparam int unsigned REG_W        = 8;
    localparam int unsigned ADDR_W       = 4;
    // Byte addresses of the word-aligned registers
    localparam logic [ADDR_W-1:0] OFS_RISE_EN  = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_FALL_EN  = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_FLAGS    = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CTRL = 4'hc;
    // Fields of irq_control_reg
    localparam int unsigned IRQ_MASTER_BIT  = 0;
    localparam int unsigned IRQ_SUMMARY_BIT = 1;
    // Reset values
    localparam logic [NUM_PINS-1:0] RST_RISE_EN = 6'h00;
    localparam logic [NUM_PINS-1:0] RST_FALL_EN = 6'h00;
    localparam logic [NUM_PINS-1:0] RST_FLAGS   = 6'h00;
    localparam logic                RST_MASTER  = 1'b0;
    localparam logic [31:0]         RDATA_ZERO  = 32'h0000_0000;
    // Answer returned to an unmapped read
    localparam logic [31:0]         RDATA_UNMAPPED = 32'h0000_0000;

    typedef enum logic [1:0] {
        PCED_IDLE = 2'b01,
        PCED_DONE = 2'b10
    } pced_bus_state_t;
endpackage : pced_pkg

// ### pced_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
module pced_pin_sync #(
    parameter int unsigned WIDTH = 6
) (
    input  wire logic             clk,     // System clock
    input  wire logic             rstn,    // Synchronous reset, low active
    input  wire logic [WIDTH-1:0] pin_in,  // Asynchronous pin levels
    output logic      [WIDTH-1:0] rise,    // One-cycle rising pulse
    output logic      [WIDTH-1:0] fall     // One-cycle falling pulse
);
    import pced_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] level;
        logic [WIDTH-1:0] rise;
        logic [WIDTH-1:0] fall;
    } pced_sync_t;

    pced_sync_t st;
    pced_sync_t next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = pin_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < WIDTH; i++) begin
            // A change counts only once stages two and three agree
            if (st.s2[i] == st.s3[i]) begin
                next_st.level[i] = st.s2[i];
            end
            next_st.rise[i] = (st.s2[i] == st.s3[i]) && st.s2[i] && !st.level[i];
            next_st.fall[i] = (st.s2[i] == st.s3[i]) && !st.s2[i] && st.level[i];
        end
        if (!rstn) begin
            next_st = '0;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign rise = st.rise;
    assign fall = st.fall;
endmodule : pced_pin_sync

// ### pced_top.sv
// Port change edge detector with Avalon-MM register slave
//
// Contract
// - A set rise enable bit 5..0 arms rising-edge detection on its pin.
// - A set fall enable bit 5..0 arms falling-edge detection on its pin.
// - A clear enable bit yields no event for that pin and direction.
// - An enabled rising or falling edge sets that pin's flag bit.
// - Any flag set by an edge also raises the summary flag.
// - A flag reads zero after reset or after software clears it.
// - Flags are software read/write and hardware settable independently.
// - Bits 7 and 6 of enables and flags read zero and ignore writes.
// - A change event wakes from sleep only when the master enable is set.
// - Flags caught in sleep are updated on the same edge that wake is signalled.
// - Detection and flag setting go on with the master enable clear.
// - The summary flag is the OR of all pin flags.
// - An edge during a software clear leaves the flag set.
// - Both enables set detect edges of either polarity.
module pced_top #(
    parameter int unsigned NUM_PIN = pced_pkg::NUM_PINS
) (
    input  wire logic                       clk,               // 40 MHz system clock
    input  wire logic                       rstn,              // Synchronous reset, low active
    input  wire logic [NUM_PIN-1:0]         pin_port,          // Port pin levels
    input  wire logic                       sleep_mode,        // Core is in sleep
    input  wire logic [pced_pkg::ADDR_W-1:0] avs_address,      // Byte address
    input  wire logic                       avs_read,          // Read request
    input  wire logic                       avs_write,         // Write request
    input  wire logic [31:0]                avs_writedata,     // Write data
    input  wire logic [3:0]                 avs_byteenable,    // Byte lanes
    output logic      [31:0]                avs_readdata,      // Read data
    output logic                            avs_waitrequest,   // Stall
    output logic                            irq,               // Change interrupt
    output logic                            wake               // Sleep wake request
);
    import pced_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        pced_bus_state_t    bus;
        logic [NUM_PIN-1:0] rise_edge_enable;
        logic [NUM_PIN-1:0] fall_edge_enable;
        logic [NUM_PIN-1:0] pin_change_flags;
        logic               change_irq_master_enable;
        logic [31:0]        rdata;
        logic               wake;
    } pced_state_t;

    pced_state_t        st;
    pced_state_t        next_st;
    logic [NUM_PIN-1:0] rise_pulse;
    logic [NUM_PIN-1:0] fall_pulse;
    logic [NUM_PIN-1:0] hit;
    logic               change_irq_summary;
    logic               req;
    logic               lane0;

    ////////////////////////////////////////////////////////////////////////////
    // Pin sampling

    pced_pin_sync #(
        .WIDTH (NUM_PIN)
    ) u_sync (
        .clk    (clk),
        .rstn   (rstn),
        .pin_in (pin_port),
        .rise   (rise_pulse),
        .fall   (fall_pulse)
    );

    // Either polarity passes when both enables are set; master enable not consulted
    for (genvar p = 0; p < NUM_PIN; p++) begin : g_pin
        logic rise_hit;
        logic fall_hit;
        assign rise_hit = rise_pulse[p] && st.rise_edge_enable[p];
        assign fall_hit = fall_pulse[p] && st.fall_edge_enable[p];
        assign hit[p]   = rise_hit || fall_hit;
    end

    assign change_irq_summary = |st.pin_change_flags;
    assign req   = avs_read || avs_write;
    assign lane0 = avs_byteenable[0];

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_st      = st;
        next_st.wake = 1'b0;
        case (st.bus)
            PCED_IDLE: begin
                // One wait cycle, so read data comes from a flop
                if (req) begin
                    next_st.bus   = PCED_DONE;
                    next_st.rdata = RDATA_ZERO;
                    if (avs_read) begin
                        case (avs_address)
                            OFS_RISE_EN:  next_st.rdata[NUM_PIN-1:0] = st.rise_edge_enable;
                            OFS_FALL_EN:  next_st.rdata[NUM_PIN-1:0] = st.fall_edge_enable;
                            OFS_FLAGS:    next_st.rdata[NUM_PIN-1:0] = st.pin_change_flags;
                            OFS_IRQ_CTRL: begin
                                next_st.rdata[IRQ_MASTER_BIT]  = st.change_irq_master_enable;
                                next_st.rdata[IRQ_SUMMARY_BIT] = change_irq_summary;
                            end
                            default:      next_st.rdata = RDATA_UNMAPPED;
                        endcase
                    end
                end
            end
            PCED_DONE: begin
                // Write lands on the edge that ends the request
                next_st.bus = PCED_IDLE;
                if (avs_write && lane0) begin
                    case (avs_address)
                        OFS_RISE_EN:  next_st.rise_edge_enable =
                                          avs_writedata[NUM_PIN-1:0];
                        OFS_FALL_EN:  next_st.fall_edge_enable =
                                          avs_writedata[NUM_PIN-1:0];
                        OFS_FLAGS:    next_st.pin_change_flags =
                                          avs_writedata[NUM_PIN-1:0];
                        OFS_IRQ_CTRL: next_st.change_irq_master_enable =
                                          avs_writedata[IRQ_MASTER_BIT];
                        default:      next_st.bus = PCED_IDLE;
                    endcase
                end
            end
            default: next_st.bus = PCED_IDLE;
        endcase
        // Hardware set after the write so it wins over a clearing write
        next_st.pin_change_flags = next_st.pin_change_flags | hit;
        // Flag is in place the same edge wake rises, so software sees it first
        next_st.wake = sleep_mode && st.change_irq_master_enable && (|hit);
        if (!rstn) begin
            next_st.bus                      = PCED_IDLE;
            next_st.rise_edge_enable         = RST_RISE_EN;
            next_st.fall_edge_enable         = RST_FALL_EN;
            next_st.pin_change_flags         = RST_FLAGS;
            next_st.change_irq_master_enable = RST_MASTER;
            next_st.rdata                    = RDATA_ZERO;
            next_st.wake                     = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign avs_readdata    = st.rdata;
    assign avs_waitrequest = req && (st.bus != PCED_DONE);
    assign irq             = change_irq_summary && st.change_irq_master_enable;
    assign wake            = st.wake;
endmodule : pced_top

// ### pced_props.sv
// Checker of bus timing, readback and change interrupt outputs
module pced_props
    import pced_pkg::*;
#(parameter int unsigned NUM_PIN = 6) (
    input wire logic               clk,             // Clock
    input wire logic               rstn,            // Reset
    input wire logic [NUM_PIN-1:0] pin_port,        // Pins
    input wire logic               sleep_mode,      // Sleep
    input wire logic [ADDR_W-1:0]  avs_address,     // Bus
    input wire logic               avs_read,        // Bus
    input wire logic               avs_write,       // Bus
    input wire logic [31:0]        avs_writedata,   // Bus
    input wire logic [3:0]         avs_byteenable,  // Bus
    input wire logic [31:0]        avs_readdata,    // Bus
    input wire logic               avs_waitrequest, // Bus
    input wire logic               irq,             // Interrupt
    input wire logic               wake             // Wake
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire logic req = avs_read | avs_write;
    sequence s_done; req && !avs_waitrequest; endsequence
    sequence s_rd; avs_read && !avs_waitrequest; endsequence
    property p_wait; req && !$past(req) |-> avs_waitrequest; endproperty
    a_wait: assert property (p_wait) else $error("no wait cycle");
    property p_stand; !req |=> $stable(avs_readdata); endproperty
    a_stand: assert property (p_stand) else $error("readdata moved");
    property p_top; s_rd |-> avs_readdata[31:6] == '0; endproperty
    a_top: assert property (p_top) else $error("upper bits set");
    property p_unmap; s_rd ##0 avs_address[1:0] != 2'h0 |-> avs_readdata == '0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped data");
    property p_sum; s_rd ##0 (avs_address == OFS_IRQ_CTRL && avs_readdata[0])
        |-> avs_readdata[1] == $past(irq); endproperty
    a_sum: assert property (p_sum) else $error("summary differs");
    property p_off; s_done ##0 (avs_write && avs_address == OFS_IRQ_CTRL
        && avs_byteenable[0] && !avs_writedata[0]) |=> !irq; endproperty
    a_off: assert property (p_off) else $error("irq while disabled");
    property p_wkirq; wake |-> irq; endproperty
    a_wkirq: assert property (p_wkirq) else $error("wake without flag");
    property p_wkslp; wake |-> $past(sleep_mode); endproperty
    a_wkslp: assert property (p_wkslp) else $error("wake while awake");
endmodule : pced_props

// ### pced_pin_src.sv
// Behavioural source of the port pin levels
module pced_pin_src #(parameter int unsigned NUM_PIN = 6) (
    input  wire logic               clk,  // Clock
    output logic      [NUM_PIN-1:0] pins  // Pin levels
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pins = '0;
    // Levels move just after an edge, so the sampling is never racy
    task automatic drive(input logic [NUM_PIN-1:0] v);
        pins <= v;
        @(posedge clk);
    endtask : drive
endmodule : pced_pin_src

// ### pced_top_tb.sv
// Self-checking bench of the port change edge detector
module pced_top_tb;
    import pced_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
    logic        clk = 1'b0, rstn = 1'b0, sleep_mode = 1'b0, irq, wake, avs_waitrequest;
    logic        avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'h1;
    logic [5:0]  pin_port;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
    int          errors = 0, cmp_count = 0, wakes = 0;
    always #12.5 clk = ~clk;
    always @(posedge clk) if (wake === 1'b1) wakes++;
    pced_top u_pced_top (.clk(clk), .rstn(rstn), .pin_port(pin_port),
        .sleep_mode(sleep_mode), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .wake(wake));
    pced_pin_src u_pced_pin_src (.clk(clk), .pins(pin_port));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    // Extra idle edge after release keeps two requests from sharing a time step
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= 32'(d);
        n = 0;
        do begin @(posedge clk); n++; end while (avs_waitrequest !== 1'b0 && n < 64);
        if (n >= 64) begin errors++; wrap_up(); end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        `CHK(q, 32'(e))
    endtask : rd_chk
    // Mask of known flags, then a fresh read ANDed with it, so new edges survive
    task automatic clr_flags();
        logic [7:0] m;
        bus(1'b0, OFS_FLAGS, 8'h00);
        m = q[7:0] ^ 8'hff;
        bus(1'b0, OFS_FLAGS, 8'h00);
        bus(1'b1, OFS_FLAGS, q[7:0] & m);
    endtask : clr_flags
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 16; i += 4) rd_chk(4'(i), 8'h00);
        rd_chk(4'h2, 8'h00);
        bus(1'b1, OFS_RISE_EN, 8'hd5);
        bus(1'b1, OFS_FALL_EN, 8'he6);
        rd_chk(OFS_RISE_EN, 8'h15);
        rd_chk(OFS_FALL_EN, 8'h26);
        avs_byteenable <= 4'h0;
        bus(1'b1, OFS_RISE_EN, 8'h00);
        avs_byteenable <= 4'h1;
        rd_chk(OFS_RISE_EN, 8'h15);
        u_pced_pin_src.drive(6'h3f);
        repeat (8) @(posedge clk);
        `CHK(irq, 1'b0)
        rd_chk(OFS_FLAGS, 8'h15);
        rd_chk(OFS_IRQ_CTRL, 8'h02);
        clr_flags();
        rd_chk(OFS_FLAGS, 8'h00);
        u_pced_pin_src.drive(6'h00);
        repeat (8) @(posedge clk);
        rd_chk(OFS_FLAGS, 8'h26);
        bus(1'b1, OFS_IRQ_CTRL, 8'h01);
        `CHK(irq, 1'b1)
        rd_chk(OFS_IRQ_CTRL, 8'h03);
        clr_flags();
        `CHK(irq, 1'b0)
        sleep_mode <= 1'b1;
        u_pced_pin_src.drive(6'h3f);
        repeat (8) @(posedge clk);
        `CHK(wakes, 1)
        rd_chk(OFS_FLAGS, 8'h15);
        bus(1'b1, OFS_IRQ_CTRL, 8'h00);
        clr_flags();
        u_pced_pin_src.drive(6'h00);
        repeat (8) @(posedge clk);
        `CHK(wakes, 1)
        rd_chk(OFS_FLAGS, 8'h26);
        // Clearing write lands on the very edge that sets the new flags
        u_pced_pin_src.drive(6'h3f);
        repeat (2) @(posedge clk);
        bus(1'b1, OFS_FLAGS, 8'h00);
        rd_chk(OFS_FLAGS, 8'h15);
        wrap_up();
    end
endmodule : pced_top_tb

bind pced_top pced_props #(.NUM_PIN(NUM_PIN)) u_pced_props (.clk(clk), .rstn(rstn),
    .pin_port(pin_port), .sleep_mode(sleep_mode), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .wake(wake));
